// file: logic/host_bus_strap_and_decode.sv
// host port: strap configuration, clock divide, space decode and hold-off
// ******************************************
// Overview of operation
// - the seven straps are sampled when reset is released and fix the configuration.
// - bus select straps 1,0,1,1 select generic bus 1 with big-endian byte order.
// - the hold-off strap sets hold-off polarity: one is active high, zero active low.
// - the clock divide strap gives a bus clock of half the input clock when one, equal when zero.
// - space select low addresses the register block, high the block with the 112K display buffer.
// - a read at register offset 00h returns the revision code.
// - hold-off stays active until read data is ready or write data is taken.
// ******************************************
`timescale 1ns/1ns
module host_bus_strap_and_decode
    import host_port_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = REVISION_CODE_DEFAULT
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic bus_select_strap_high_i,
    input wire logic [2:0] bus_select_straps_low_i,
    input wire logic reserved_strap_i,
    input wire logic holdoff_polarity_strap_i,
    input wire logic clock_divide_strap_i,
    input wire logic cs_n_i,
    input wire logic space_select_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic rd_n_i,
    input wire logic [1:0] we_n_i,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic data_oe_o,
    output logic holdoff_o,
    output logic res_req_o,
    output logic res_we_o,
    output logic res_space_o,
    output logic [ADDR_W-1:0] res_addr_o,
    output logic [15:0] res_wdata_o,
    output logic [1:0] res_be_o,
    input wire logic res_ack_i,
    input wire logic [15:0] res_rdata_i,
    output logic generic_mode_o,
    output logic big_endian_o,
    output logic strap_error_o,
    output logic bclk_en_o
);

    // ******************************************
    // reset release
    // ******************************************
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    // ******************************************
    // straps
    // ******************************************
    logic [STRAP_W-1:0] strap;
    logic strap_valid;
    logic [3:0] bus_code;
    logic pol;
    logic div;
    logic mode_ok;

    strap_sampler u_straps
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .strap_i({clock_divide_strap_i, holdoff_polarity_strap_i, bus_select_strap_high_i,
                  reserved_strap_i, bus_select_straps_low_i}),
        .strap_o(strap),
        .valid_o(strap_valid)
    );

    assign bus_code = {strap[STRAP_BUS_HIGH], strap[STRAP_BUS_LOW_LSB +: 3]};
    assign pol = strap[STRAP_HOLDOFF_POL];
    assign div = strap[STRAP_CLK_DIV];
    assign mode_ok = strap_valid && bus_code == BUS_GENERIC1_BE;

    // ******************************************
    // access state
    // ******************************************
    typedef struct packed {
        access_state_t st;
        logic en;
        logic holdoff;
        logic [15:0] rdata;
        logic oe;
        logic req;
        logic req_we;
        logic req_space;
        logic [ADDR_W-1:0] req_addr;
        logic [15:0] req_wdata;
        logic [1:0] req_be;
        logic mode;
        logic big;
        logic err;
    } port_t;

    port_t q, d;
    logic take;
    logic is_read;
    logic local_hit;
    logic [15:0] rev_word;

    function automatic logic [15:0] order(input logic swap, input logic [15:0] w);
        order = swap ? {w[7:0], w[15:8]} : w;
    endfunction

    assign is_read = !rd_n_i;
    assign take = q.en && q.st == ST_IDLE && q.mode && !cs_n_i && (is_read || we_n_i != 2'h3);
    // revision code and the unused tail of the buffer block answer without arbitration
    assign local_hit = space_select_i ? (addr_i >= BUFFER_LIMIT) : (addr_i == REVISION_CODE_OFFSET);
    assign rev_word = order(q.big, {8'h00, REVISION_CODE});

    always_comb
    begin
        d = q;
        d.mode = mode_ok;
        d.big = mode_ok;
        d.err = strap_valid && !strap[STRAP_RESERVED];
        // bus clock enable: every cycle, or every other one when divided
        d.en = (strap_valid && div) ? !q.en : 1'b1;
        unique case (q.st)
            ST_IDLE:
            begin
                if (take)
                begin
                    d.oe = is_read;
                    if (local_hit)
                    begin
                        d.st = ST_DONE;
                        d.rdata = space_select_i ? 16'h0000 : rev_word;
                    end
                    else
                    begin
                        d.st = ST_WAIT;
                        d.req = 1'b1;
                        d.req_we = !is_read;
                        d.req_space = space_select_i;
                        d.req_addr = addr_i;
                        d.req_wdata = order(q.big, data_i);
                        d.req_be = q.big ? {!we_n_i[0], !we_n_i[1]} : ~we_n_i;
                    end
                end
            end
            ST_WAIT:
            begin
                // held here while the internal arbiter serves refresh first
                if (res_ack_i)
                begin
                    d.st = ST_DONE;
                    d.req = 1'b0;
                    d.rdata = order(q.big, res_rdata_i);
                end
            end
            ST_DONE:
            begin
                if (q.en && cs_n_i)
                begin
                    d.st = ST_IDLE;
                    d.oe = 1'b0;
                end
            end
        endcase
        d.holdoff = (d.st == ST_WAIT) ? pol : !pol;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            q <= '{st: ST_IDLE, en: 1'b1, holdoff: 1'b0, rdata: 16'h0000, oe: 1'b0, req: 1'b0,
                   req_we: 1'b0, req_space: 1'b0, req_addr: 17'h0_0000, req_wdata: 16'h0000,
                   req_be: 2'h0, mode: 1'b0, big: 1'b0, err: 1'b0};
        else
            q <= d;
    end

    assign data_o = q.rdata;
    assign data_oe_o = q.oe;
    assign holdoff_o = q.holdoff;
    assign res_req_o = q.req;
    assign res_we_o = q.req_we;
    assign res_space_o = q.req_space;
    assign res_addr_o = q.req_addr;
    assign res_wdata_o = q.req_wdata;
    assign res_be_o = q.req_be;
    assign generic_mode_o = q.mode;
    assign big_endian_o = q.big;
    assign strap_error_o = q.err;
    assign bclk_en_o = q.en;

    // ******************************************
    // assertions
    // ******************************************
    a_mode_decode: assert property (@(posedge clk_i) disable iff (!rst_n)
        strap_valid |=> generic_mode_o == (bus_code == BUS_GENERIC1_BE) && big_endian_o == generic_mode_o)
        else $error("bus mode does not follow bus select straps");
    a_holdoff_level: assert property (@(posedge clk_i) disable iff (!rst_n)
        (strap_valid && $past(strap_valid) && q.st != ST_WAIT) |-> holdoff_o == !pol)
        else $error("idle hold-off level wrong for polarity strap");
    a_divide_rate: assert property (@(posedge clk_i) disable iff (!rst_n)
        (strap_valid && bclk_en_o) |=> bclk_en_o == !div)
        else $error("bus clock enable rate wrong for divide strap");
    a_space_route: assert property (@(posedge clk_i) disable iff (!rst_n)
        $rose(res_req_o) |-> res_space_o == $past(space_select_i) && res_addr_o == $past(addr_i))
        else $error("request routed to wrong block");
    a_revision_read: assert property (@(posedge clk_i) disable iff (!rst_n)
        (take && is_read && !space_select_i && addr_i == REVISION_CODE_OFFSET)
        |=> (data_o == order(big_endian_o, {8'h00, REVISION_CODE}) && data_oe_o && !res_req_o))
        else $error("revision read did not return revision code");
    a_holdoff_wait: assert property (@(posedge clk_i) disable iff (!rst_n)
        res_req_o |-> holdoff_o == pol)
        else $error("hold-off released while access pending");
    a_holdoff_release: assert property (@(posedge clk_i) disable iff (!rst_n)
        (res_req_o && res_ack_i) |=> (holdoff_o == !pol && !res_req_o) ##1 holdoff_o == !pol)
        else $error("hold-off not released after acknowledge");

    c_rev_read: cover property (@(posedge clk_i) disable iff (!rst_n)
        take && is_read && !space_select_i && addr_i == REVISION_CODE_OFFSET);
    c_buffer_write: cover property (@(posedge clk_i) disable iff (!rst_n)
        res_req_o && res_we_o && res_space_o ##[1:20] res_ack_i);
    c_divided_clock: cover property (@(posedge clk_i) disable iff (!rst_n)
        strap_valid && div && take);

endmodule

// file: logic/host_port_pkg.sv
// constants and types shared by the host port strap and decode logic
package host_port_pkg;

    // ******************************************
    // strap positions in the sampled strap word
    // ******************************************
    localparam int STRAP_W = 7;
    localparam int STRAP_BUS_LOW_LSB = 0;
    localparam int STRAP_RESERVED = 3;
    localparam int STRAP_BUS_HIGH = 4;
    localparam int STRAP_HOLDOFF_POL = 5;
    localparam int STRAP_CLK_DIV = 6;
    localparam logic [STRAP_W-1:0] STRAP_RESET = 7'h00;
    // cycles after reset release before the synchronised straps are trusted
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

    // bus select code {high, low[2:0]} for generic bus 1, big endian
    localparam logic [3:0] BUS_GENERIC1_BE = 4'hB;

    // ******************************************
    // address map inside each 128K block
    // ******************************************
    localparam int ADDR_W = 17;
    localparam logic [ADDR_W-1:0] REVISION_CODE_OFFSET = 17'h0_0000;
    // display buffer is 112K, the rest of its block is unmapped
    localparam logic [ADDR_W-1:0] BUFFER_LIMIT = 17'h1_C000;
    // arbitrary value, no meaning
    localparam logic [7:0] REVISION_CODE_DEFAULT = 8'h5A;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } access_state_t;

endpackage

// file: logic/strap_sampler.sv
// captures the configuration straps once after reset release
`timescale 1ns/1ns
module strap_sampler
    import host_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [STRAP_W-1:0] strap_i,
    output logic [STRAP_W-1:0] strap_o,
    output logic valid_o
);

    typedef struct packed {
        logic [STRAP_W-1:0] s1;
        logic [STRAP_W-1:0] s2;
        logic [STRAP_W-1:0] s3;
        logic [1:0] cnt;
        logic valid;
        logic [STRAP_W-1:0] val;
    } sampler_t;

    sampler_t q, d;

    always_comb
    begin
        d = q;
        d.s1 = strap_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.cnt != STRAP_SETTLE_CYCLES)
            d.cnt = q.cnt + 2'h1;
        // capture once after the settle count with the pins stable, then frozen until next reset
        if (!q.valid && q.cnt == STRAP_SETTLE_CYCLES && q.s2 == q.s3)
        begin
            d.val = q.s3;
            d.valid = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q <= '{s1: STRAP_RESET, s2: STRAP_RESET, s3: STRAP_RESET, cnt: 2'h0, valid: 1'b0, val: STRAP_RESET};
        else
            q <= d;
    end

    assign strap_o = q.val;
    assign valid_o = q.valid;

    // ******************************************
    // assertions
    // ******************************************
    a_strap_capture_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(q.valid) |-> q.val == $past(q.s3))
        else $error("strap word differs from synchronised pins");
    a_strap_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        q.valid |=> (q.valid && $stable(q.val)))
        else $error("strap word changed after capture");

endmodule

// file: tb/arbiter_model.sv
// behavioural internal arbiter and display memory behind the request port
`timescale 1ns/1ns
module arbiter_model
    import host_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [1:0] be_i,
    input wire logic [3:0] wait_i,
    output logic ack_o,
    output logic [15:0] rdata_o
);
    logic [15:0] mem [16];
    logic [3:0] cnt = 4'h0;
    initial ack_o = 1'b0;
    initial rdata_o = 16'h0000;
    // refresh contention shows as a wait of wait_i cycles before each ack
    always @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        // read data is not held once the ack has gone
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o)
        begin
            if (cnt == wait_i)
            begin
                cnt <= 4'h0;
                ack_o <= 1'b1;
                rdata_o <= mem[addr_i[4:1]];
                if (we_i && be_i[0])
                    mem[addr_i[4:1]][7:0] <= wdata_i[7:0];
                if (we_i && be_i[1])
                    mem[addr_i[4:1]][15:8] <= wdata_i[15:8];
            end
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the host port strap and decode block
`timescale 1ns/1ns
module tb_top;
    import host_port_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic bs_hi = 1'b0;
    logic [2:0] bs_lo = 3'h0;
    // reserved strap at one in every strap set sampled at reset; bus start input has no port, the board holds it high
    logic rsv = 1'b1;
    logic pol = 1'b0;
    logic div = 1'b0;
    logic cs_n = 1'b1;
    logic space = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic rd_n = 1'b1;
    logic [1:0] we_n = 2'b11;
    logic [15:0] wdata = 16'h0000;
    logic [3:0] wait_n = 4'h0;
    logic [15:0] data_o, res_wdata, res_rdata, rd_val, s_wd;
    logic data_oe, holdoff, res_req, res_we, res_space, res_ack, gen, big, serr, bclk_en, s_we, s_sp, b;
    logic oe_seen;
    logic [ADDR_W-1:0] res_addr, s_addr;
    logic [1:0] res_be, s_be;
    int failures = 0;
    int n_tests = 0;
    int hold_cnt = 0;
    int req_cnt = 0;

    host_bus_strap_and_decode uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_select_strap_high_i(bs_hi),
        .bus_select_straps_low_i(bs_lo), .reserved_strap_i(rsv), .holdoff_polarity_strap_i(pol),
        .clock_divide_strap_i(div), .cs_n_i(cs_n), .space_select_i(space), .addr_i(addr), .rd_n_i(rd_n),
        .we_n_i(we_n), .data_i(wdata), .data_o(data_o), .data_oe_o(data_oe), .holdoff_o(holdoff),
        .res_req_o(res_req), .res_we_o(res_we), .res_space_o(res_space), .res_addr_o(res_addr),
        .res_wdata_o(res_wdata), .res_be_o(res_be), .res_ack_i(res_ack), .res_rdata_i(res_rdata),
        .generic_mode_o(gen), .big_endian_o(big), .strap_error_o(serr), .bclk_en_o(bclk_en));

    arbiter_model far_end (.clk_i(clk_i), .req_i(res_req), .we_i(res_we), .addr_i(res_addr),
        .wdata_i(res_wdata), .be_i(res_be), .wait_i(wait_n), .ack_o(res_ack), .rdata_o(res_rdata));

    initial forever #5 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        if (res_req === 1'b1 && res_ack === 1'b1)
        begin
            {s_we, s_sp, s_be, s_addr, s_wd} = {res_we, res_space, res_be, res_addr, res_wdata};
            req_cnt++;
        end
        if (holdoff === pol)
            hold_cnt++;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic close_out;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // straps are set at reset assertion and held through release and the settle wait
    task automatic do_reset(input logic [6:0] s);
        @(negedge clk_i);
        reset_n_i = 1'b0;
        {div, pol, bs_hi, rsv, bs_lo} = s;
        repeat (20) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (12) @(negedge clk_i);
    endtask

    // one single 16-bit transfer at a time, in order, never a burst
    task automatic access(input logic sp, input logic [ADDR_W-1:0] a, input logic wr, input logic [15:0] d,
        output logic [15:0] q);
        int i;
        @(negedge clk_i);
        hold_cnt = 0;
        space = sp;
        addr = a;
        rd_n = wr;
        we_n = wr ? 2'b00 : 2'b11;
        wdata = d;
        // select trails the address by one input clock, half a bus clock when divided
        @(negedge clk_i);
        cs_n = 1'b0;
        repeat (3) @(negedge clk_i);
        // access ends on the hold-off, not on a wait-state count
        for (i = 0; i < 40 && holdoff === pol; i++)
            @(negedge clk_i);
        // a hung access is counted here; the run still goes on to the closing report
        if (i == 40)
            failures++;
        q = data_o;
        oe_seen = data_oe;
        cs_n = 1'b1;
        rd_n = 1'b1;
        we_n = 2'b11;
        repeat (3) @(negedge clk_i);
    endtask

    initial
    begin
        do_reset(7'h3B);
        check(16'({gen, big, serr, bclk_en, holdoff}), 16'h001A, "straps 1011");
        @(negedge clk_i);
        check(16'(bclk_en), 16'h0001, "undivided clock");
        access(1'b0, REVISION_CODE_OFFSET, 1'b0, 16'h0000, rd_val);
        check(rd_val[15:8], 16'(REVISION_CODE_DEFAULT), "revision");
        check(16'(oe_seen), 16'h0001, "read drives data");
        access(1'b0, REVISION_CODE_OFFSET, 1'b1, 16'hFFFF, rd_val);
        check(16'(oe_seen), 16'h0000, "write leaves data undriven");
        access(1'b0, REVISION_CODE_OFFSET, 1'b0, 16'h0000, rd_val);
        check(rd_val[15:8], 16'(REVISION_CODE_DEFAULT), "revision after write");
        for (int w = 0; w < 6; w += 5)
        begin
            wait_n = 4'(w);
            access(1'b1, 17'h0_0010, 1'b1, 16'h1234 + 16'(w), rd_val);
            check({s_we, s_sp, s_be, 12'h000}, 16'hF000, "buffer write fields");
            check(s_addr[15:0], 16'h0010, "buffer write address");
            check(s_wd, 16'h3412 + 16'(w << 8), "byte order");
            check(16'(hold_cnt > w), 16'h0001, "hold-off through wait");
            access(1'b1, 17'h0_0010, 1'b0, 16'h0000, rd_val);
            check(rd_val, 16'h1234 + 16'(w), "buffer read back");
        end
        access(1'b0, 17'h0_0002, 1'b0, 16'h0000, rd_val);
        check(16'({s_sp, s_we}), 16'h0000, "register block read");
        access(1'b1, BUFFER_LIMIT, 1'b0, 16'h0000, rd_val);
        check(rd_val, 16'h0000, "unmapped buffer tail");
        @(negedge clk_i);
        {div, pol, bs_hi, rsv, bs_lo} = 7'h40;
        repeat (6) @(negedge clk_i);
        check(16'({gen, big, serr, bclk_en}), 16'h000D, "straps frozen");
        {div, pol, bs_hi, rsv, bs_lo} = 7'h3B;
        do_reset(7'h5B);
        check(16'({gen, serr, holdoff}), 16'h0005, "second strap set");
        b = bclk_en;
        @(negedge clk_i);
        check(16'(bclk_en), 16'(!b), "divided clock");
        wait_n = 4'h2;
        access(1'b1, 17'h0_0004, 1'b1, 16'hA55A, rd_val);
        check(16'(hold_cnt > 2), 16'h0001, "active low hold-off");
        access(1'b1, 17'h0_0004, 1'b0, 16'h0000, rd_val);
        check(rd_val, 16'hA55A, "divided read back");
        do_reset(7'h3A);
        check(16'(gen), 16'h0000, "other bus code");
        req_cnt = 0;
        access(1'b1, 17'h0_0004, 1'b0, 16'h0000, rd_val);
        check(16'(req_cnt), 16'h0000, "port inert");
        check(16'(oe_seen), 16'h0000, "inert port undriven");
        close_out();
    end
endmodule
